// ### hw/psd_map.svh
`ifndef PSD_MAP_SVH
`define PSD_MAP_SVH

`define PSD_MOD_LOW 7'd80
`define PSD_MOD_HIGH 7'd81
`define PSD_DIGIT_W 4
`define PSD_STEP_W 3
`define PSD_DECADE_MAX 4'h9
`define PSD_BINARY_MAX 4'hf
`define PSD_HUNDREDS_FIXED 4'h1
`define PSD_CLK_PERIOD_NS 20
`define PSD_LOOP_MAX_NS 700
`define PSD_LOOP_CYCLES (`PSD_LOOP_MAX_NS / `PSD_CLK_PERIOD_NS)
`define PSD_PRESET_MAX_NS 350
`define PSD_PRESET_CYCLES (`PSD_PRESET_MAX_NS / `PSD_CLK_PERIOD_NS)
`define PSD_PRESET_STRETCH 1

`endif

// ### hw/psd_pkg.sv
package psd_pkg;
  typedef enum logic [0:0] {
    PSD_COUNT = 1'b0,
    PSD_PRESET = 1'b1
  } psd_phase_t;
endpackage : psd_pkg

// ### hw/psd_digit.sv
`timescale 1ns/1ps
`default_nettype none
`include "psd_map.svh"

// ==========================================
// One 4-bit down counter, binary or decade
module psd_digit #(
  parameter bit BINARY = 1'b0
) (
  input wire logic sys_clk,
  input wire logic load,
  input wire logic [3:0] load_value,
  input wire logic count_en,
  output logic [3:0] value,
  output logic terminal
);
  logic [3:0] value_reg;

  always_ff @(posedge sys_clk) begin
    if (load) begin
      value_reg <= load_value;
    end else if (count_en) begin
      if (value_reg == 4'h0) begin
        value_reg <= BINARY ? `PSD_BINARY_MAX : `PSD_DECADE_MAX;
      end else begin
        value_reg <= value_reg - 4'h1;
      end
    end
  end

  assign value = value_reg;
  assign terminal = count_en && (value_reg == 4'h0);
endmodule : psd_digit
`default_nettype wire

// ### hw/psd_divider.sv
`timescale 1ns/1ps
`default_nettype none
`include "psd_map.svh"

module psd_divider #(
  parameter bit UHF_VARIANT = 1'b0
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [2:0] step_digit,
  input wire logic [3:0] hundreds_khz_digit,
  input wire logic [3:0] units_mhz_digit,
  input wire logic [3:0] tens_mhz_digit,
  output logic modulus_high,
  output logic preset_pulse,
  output logic cycle_out,
  output logic [3:0] swallow_counter_low_digit,
  output logic [3:0] swallow_counter_high_digit,
  output logic [3:0] main_counter_units_mhz,
  output logic [3:0] main_counter_tens_mhz,
  output logic [3:0] main_counter_hundreds_mhz
);
  // ==========================================
  // Clock qualification and cycle control
  logic half_reg;
  logic tick;
  logic load;
  logic swallow_zero;
  logic swallow_en;
  logic main_zero;
  logic [4:0] term;
  logic [3:0] vals [5];
  logic [3:0] loads [5];
  logic [4:0] ens;
  psd_pkg::psd_phase_t phase_reg;
  logic cycle_reg;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      half_reg <= 1'b0;
    end else begin
      half_reg <= ~half_reg;
    end
  end
  assign tick = UHF_VARIANT ? half_reg : 1'b1;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      phase_reg <= psd_pkg::PSD_PRESET;
    end else if (tick && phase_reg == psd_pkg::PSD_PRESET) begin
      phase_reg <= psd_pkg::PSD_COUNT;
    end else if (tick && main_zero) begin
      phase_reg <= psd_pkg::PSD_PRESET;
    end
  end
  // Preset lasts one cycle (two with UHF_VARIANT); its one-cycle load loads every digit at once
  assign load = tick && phase_reg == psd_pkg::PSD_PRESET;
  assign preset_pulse = phase_reg == psd_pkg::PSD_PRESET;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cycle_reg <= 1'b0;
    end else begin
      cycle_reg <= tick && main_zero;
    end
  end
  assign cycle_out = cycle_reg;

  // ==========================================
  // Counter chain
  assign swallow_zero = (vals[0] == 4'h0) && (vals[1] == 4'h0);
  assign swallow_en = tick && !load && !swallow_zero;
  assign main_zero = (vals[2] == 4'h0) && (vals[3] == 4'h0) && (vals[4] == 4'h0) && !load;

  assign loads[0] = {1'b0, step_digit};
  assign loads[1] = hundreds_khz_digit;
  assign loads[2] = units_mhz_digit;
  assign loads[3] = tens_mhz_digit;
  assign loads[4] = `PSD_HUNDREDS_FIXED;

  assign ens[0] = swallow_en;
  assign ens[1] = term[0];
  assign ens[2] = tick && !load && !main_zero;
  assign ens[3] = term[2];
  assign ens[4] = term[3];

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_digit
      psd_digit #(
        .BINARY(gi == 0)
      ) u_digit (
        .sys_clk(sys_clk),
        .load(load || reset),
        .load_value(loads[gi]),
        .count_en(ens[gi]),
        .value(vals[gi]),
        .terminal(term[gi])
      );
    end
  endgenerate

  // Low swallow digit wraps to 15 when the high digit borrows
  assign modulus_high = !swallow_zero;

  assign swallow_counter_low_digit = vals[0];
  assign swallow_counter_high_digit = vals[1];
  assign main_counter_units_mhz = vals[2];
  assign main_counter_tens_mhz = vals[3];
  assign main_counter_hundreds_mhz = vals[4];

  // ==========================================
  // Checks
  property p_mod_nonzero;
    @(posedge sys_clk) disable iff (reset)
      modulus_high == ((swallow_counter_low_digit != 4'h0) || (swallow_counter_high_digit != 4'h0));
  endproperty
  a_mod_nonzero: assert property (p_mod_nonzero) else $error("modulus mismatch");

  property p_swallow_hold;
    @(posedge sys_clk) disable iff (reset)
      (!modulus_high && !load) |=> !modulus_high;
  endproperty
  a_swallow_hold: assert property (p_swallow_hold) else $error("swallow left zero");

  property p_swallow_dec;
    @(posedge sys_clk) disable iff (reset)
      (swallow_en && swallow_counter_low_digit != 4'h0) |=>
        swallow_counter_low_digit == $past(swallow_counter_low_digit) - 4'h1;
  endproperty
  a_swallow_dec: assert property (p_swallow_dec) else $error("swallow not decremented");

  property p_reload;
    @(posedge sys_clk) disable iff (reset)
      load |=> (swallow_counter_low_digit == {1'b0, $past(step_digit)}) &&
        (main_counter_units_mhz == $past(units_mhz_digit));
  endproperty
  a_reload: assert property (p_reload) else $error("reload missing");

  property p_hundreds;
    @(posedge sys_clk) disable iff (reset)
      main_counter_hundreds_mhz <= `PSD_HUNDREDS_FIXED;
  endproperty
  a_hundreds: assert property (p_hundreds) else $error("hundreds digit out of range");

  sequence s_zero_hit;
    tick && main_zero;
  endsequence
  sequence s_preset_done;
    preset_pulse ##1 !preset_pulse;
  endsequence
  property p_preset_short;
    @(posedge sys_clk) disable iff (reset)
      s_zero_hit |=> ##[0:2] s_preset_done;
  endproperty
  a_preset_short: assert property (p_preset_short) else $error("preset too long");

  property p_chain;
    @(posedge sys_clk) disable iff (reset)
      (ens[2] && main_counter_units_mhz == 4'h0) |=>
        main_counter_tens_mhz == $past(main_counter_tens_mhz) - 4'h1 || $past(main_counter_tens_mhz) == 4'h0;
  endproperty
  a_chain: assert property (p_chain) else $error("enable chain broken");

  property p_mod_quick;
    @(posedge sys_clk) disable iff (reset)
      (swallow_en && swallow_counter_low_digit == 4'h1 && swallow_counter_high_digit == 4'h0) |=> !modulus_high;
  endproperty
  a_mod_quick: assert property (p_mod_quick) else $error("modulus late");

  // ==========================================
  // Helper counters for cycle checks
  logic primed_reg;
  logic [8:0] period_reg;
  logic [8:0] ratio_reg;
  logic [8:0] ratio_next;
  logic [7:0] highs_reg;
  logic [7:0] swallow_len_reg;
  logic [7:0] swallow_len_next;
  logic [4:0] preset_len_reg;

  function automatic logic digit_ok(input logic [3:0] v, input logic bin);
    return bin || (v <= `PSD_DECADE_MAX);
  endfunction : digit_ok

  assign ratio_next = 9'((9'(`PSD_HUNDREDS_FIXED) * 9'd100) + (9'(tens_mhz_digit) * 9'd10) + 9'(units_mhz_digit));
  assign swallow_len_next = 8'({hundreds_khz_digit, 4'h0} + {5'h00, step_digit});

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      primed_reg <= 1'b0;
    end else if (load) begin
      primed_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      period_reg <= 9'h000;
      highs_reg <= 8'h00;
    end else if (load) begin
      period_reg <= 9'h000;
      highs_reg <= 8'h00;
    end else if (tick) begin
      period_reg <= period_reg + 9'h001;
      highs_reg <= highs_reg + {7'h00, modulus_high};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ratio_reg <= 9'h000;
      swallow_len_reg <= 8'h00;
    end else if (load) begin
      ratio_reg <= ratio_next;
      swallow_len_reg <= swallow_len_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      preset_len_reg <= 5'h00;
    end else if (preset_pulse) begin
      preset_len_reg <= preset_len_reg + 5'h01;
    end else begin
      preset_len_reg <= 5'h00;
    end
  end

  // ==========================================
  // Cycle level checks
  property p_period;
    @(posedge sys_clk) disable iff (reset)
      (load && primed_reg) |-> period_reg == ratio_reg + 9'h001;
  endproperty
  a_period: assert property (p_period) else $error("division cycle length wrong");

  property p_swallow_total;
    @(posedge sys_clk) disable iff (reset)
      (load && primed_reg) |-> highs_reg == swallow_len_reg;
  endproperty
  a_swallow_total: assert property (p_swallow_total) else $error("swallow length wrong");

  property p_preset_len;
    @(posedge sys_clk) disable iff (reset)
      preset_len_reg < 5'(`PSD_PRESET_CYCLES);
  endproperty
  a_preset_len: assert property (p_preset_len) else $error("preset held too long");

  sequence s_cycle_fire;
    cycle_out && preset_pulse;
  endsequence
  property p_cycle_pulse;
    @(posedge sys_clk) disable iff (reset)
      (tick && main_zero) |=> s_cycle_fire ##1 !cycle_out;
  endproperty
  a_cycle_pulse: assert property (p_cycle_pulse) else $error("cycle pulse wrong");

  property p_cycle_cause;
    @(posedge sys_clk) disable iff (reset)
      cycle_out |-> $past(tick && main_zero);
  endproperty
  a_cycle_cause: assert property (p_cycle_cause) else $error("cycle pulse without zero");

  property p_load_in_preset;
    @(posedge sys_clk) disable iff (reset)
      load |-> preset_pulse;
  endproperty
  a_load_in_preset: assert property (p_load_in_preset) else $error("load outside preset");

  sequence s_main_loaded;
    (main_counter_tens_mhz == $past(tens_mhz_digit)) && (main_counter_hundreds_mhz == `PSD_HUNDREDS_FIXED);
  endsequence
  sequence s_swallow_loaded;
    swallow_counter_high_digit == $past(hundreds_khz_digit);
  endsequence
  property p_reload_all;
    @(posedge sys_clk) disable iff (reset)
      load |=> s_main_loaded and s_swallow_loaded;
  endproperty
  a_reload_all: assert property (p_reload_all) else $error("digit not reloaded");

  property p_tick_hold;
    @(posedge sys_clk) disable iff (reset)
      !tick |=> $stable(swallow_counter_low_digit) && $stable(main_counter_units_mhz);
  endproperty
  a_tick_hold: assert property (p_tick_hold) else $error("counter moved off tick");

  generate
    for (gi = 0; gi < 5; gi++) begin : g_range
      property p_digit_range;
        @(posedge sys_clk) disable iff (reset)
          digit_ok(vals[gi], gi == 0);
      endproperty
      a_digit_range: assert property (p_digit_range) else $error("digit out of range");
    end
  endgenerate
endmodule : psd_divider
`default_nettype wire

// ### tb/psd_prescaler_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Two-modulus prescaler, counts oscillator cycles
module psd_prescaler_model (
  input wire logic sys_clk,
  input wire logic modulus_high,
  input wire logic preset_pulse,
  output logic [15:0] osc_total
);
  logic [15:0] acc_reg;
  logic [15:0] step_w;
  assign step_w = modulus_high ? 16'h0051 : 16'h0050;
  always @(posedge sys_clk) begin
    acc_reg <= preset_pulse ? 16'h0000 : acc_reg + step_w;
    if (preset_pulse) begin
      osc_total <= acc_reg + step_w;
    end
  end
endmodule : psd_prescaler_model

`default_nettype wire

// ### tb/psd_divider_tb.sv
`timescale 1ns/1ps
`default_nettype none

module pulse_swallow_programmable_divider_tb;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] step_digit = 3'h0;
  logic [3:0] hundreds_khz_digit = 4'h0;
  logic [3:0] units_mhz_digit = 4'h0;
  logic [3:0] tens_mhz_digit = 4'h0;
  logic modulus_high;
  logic preset_pulse;
  logic cycle_out;
  logic [3:0] sw_lo;
  logic [3:0] sw_hi;
  logic [3:0] mu;
  logic [3:0] mt;
  logic [3:0] mh;
  logic [15:0] osc_total;
  int n_errors = 0;
  int num_checks = 0;

  always #10 sys_clk = ~sys_clk;

  psd_divider dut_u (.sys_clk(sys_clk), .reset(reset), .step_digit(step_digit),
    .hundreds_khz_digit(hundreds_khz_digit), .units_mhz_digit(units_mhz_digit),
    .tens_mhz_digit(tens_mhz_digit), .modulus_high(modulus_high), .preset_pulse(preset_pulse),
    .cycle_out(cycle_out), .swallow_counter_low_digit(sw_lo), .swallow_counter_high_digit(sw_hi),
    .main_counter_units_mhz(mu), .main_counter_tens_mhz(mt), .main_counter_hundreds_mhz(mh));

  psd_prescaler_model model_u (.sys_clk(sys_clk), .modulus_high(modulus_high),
    .preset_pulse(preset_pulse), .osc_total(osc_total));

  // ==========================================
  // Checking and expectations
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [15:0] main_ratio(input logic [3:0] t, input logic [3:0] u);
    return 16'h0064 + {12'h000, t} * 16'h000a + {12'h000, u};
  endfunction : main_ratio

  function automatic logic [15:0] swallow_len(input logic [3:0] hk, input logic [2:0] st);
    return {8'h00, hk, 4'h0} + {13'h0000, st};
  endfunction : swallow_len

  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  // ==========================================
  // One full division cycle with a given program
  task automatic run_case(input logic [3:0] t, input logic [3:0] u, input logic [3:0] hk,
                          input logic [2:0] st);
    int ticks;
    int highs;
    logic [15:0] m;
    logic [15:0] s;
    m = main_ratio(t, u);
    s = swallow_len(hk, st);
    tens_mhz_digit = t;
    units_mhz_digit = u;
    hundreds_khz_digit = hk;
    step_digit = st;
    for (ticks = 0; preset_pulse !== 1'b1; ticks++) begin
      if (ticks > 400) begin
        n_errors++;
        give_verdict();
      end
      @(negedge sys_clk);
    end
    @(negedge sys_clk);
    check({15'h0000, preset_pulse}, 16'h0000);
    check({8'h00, sw_hi, sw_lo}, {8'h00, hk, 1'b0, st});
    check({4'h0, mh, mt, mu}, {4'h1, t, u});
    highs = 0;
    for (ticks = 0; preset_pulse !== 1'b1; ticks++) begin
      if (ticks > 400) begin
        n_errors++;
        give_verdict();
      end
      if (modulus_high === 1'b1) begin
        highs++;
      end else begin
        check({8'h00, sw_hi, sw_lo}, 16'h0000);
      end
      @(negedge sys_clk);
    end
    check({15'h0000, cycle_out}, 16'h0001);
    check(16'(ticks), m + 16'h0001);
    check(16'(highs), s);
    @(negedge sys_clk);
    check(osc_total, 16'h0050 * (m + 16'h0002) + s);
  endtask : run_case

  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(32'hd6086c71));
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
    // BCD digits, 3-bit step, ratio kept above 80 and the swallow count
    run_case(4'h0, 4'h0, 4'h0, 3'h0);
    run_case(4'h9, 4'h9, 4'h5, 3'h7);
    run_case(4'h0, 4'h0, 4'h5, 3'h7);
    repeat (12) begin
      run_case(4'($urandom_range(9)), 4'($urandom_range(9)), 4'($urandom_range(5)),
               3'($urandom_range(7)));
    end
    // Fixed channel pair as two table entries, plain codes for down counters
    run_case(4'h4, 4'h6, 4'h2, 3'h4);
    run_case(4'h4, 4'h2, 4'h1, 3'h0);
    // Reset in mid-run
    @(negedge sys_clk);
    reset = 1'b1;
    repeat (2) @(negedge sys_clk);
    check({14'h0000, preset_pulse, cycle_out}, 16'h0002);
    check({4'h0, mh, mt, mu}, {4'h1, tens_mhz_digit, units_mhz_digit});
    reset = 1'b0;
    run_case(4'h2, 4'h3, 4'h3, 3'h5);
    give_verdict();
  end
endmodule : pulse_swallow_programmable_divider_tb

`default_nettype wire
